// >>> inc/pvsc_map.vh
// Register map, field layout and timer counts for the image decoder
// and special cycle generator. Assumes a 32-bit AXI4-Lite register bus.
// Summary of operation
// - Floor field gives lowest decoded PCI address
// - Claim when at or above floor, below limit
// - Zero limit means no upper bound
// - VME upper address is PCI plus offset
// - Select field: off, read-modify-write, address-only
// - Space bit picks memory or I/O match
// - Special cycle only on exact address match
// - Read-modify-write starts on a PCI read
// - Address-only starts on read or write
// - Match address holds PCI bits 31 to 2
// - No 64-bit acknowledge on special match
// - Mask bits select compare and swap bits
// - Read data compared under mask
// - On match write swap value back
// - Unmasked bits are not written back
// - Misc register holds legacy field, timer
// - Hold timer keeps VME ownership after transfer
`ifndef PVSC_MAP_VH
`define PVSC_MAP_VH

`define PVSC_OFS_FLOOR 12'h140
`define PVSC_OFS_LIMIT 12'h144
`define PVSC_OFS_TOFF 12'h148
`define PVSC_OFS_CTL 12'h170
`define PVSC_OFS_MADR 12'h174
`define PVSC_OFS_MASK 12'h178
`define PVSC_OFS_CMP 12'h17C
`define PVSC_OFS_SWP 12'h180
`define PVSC_OFS_MISC 12'h184
`define PVSC_OFS_STAT 12'h1C0

`define PVSC_IDX_FLOOR 4'h0
`define PVSC_IDX_LIMIT 4'h1
`define PVSC_IDX_TOFF 4'h2
`define PVSC_IDX_CTL 4'h3
`define PVSC_IDX_MADR 4'h4
`define PVSC_IDX_MASK 4'h5
`define PVSC_IDX_CMP 4'h6
`define PVSC_IDX_SWP 4'h7
`define PVSC_IDX_MISC 4'h8
`define PVSC_IDX_STAT 4'h9
`define PVSC_IDX_NONE 4'hF
`define PVSC_NREG 9

`define PVSC_WM_IMG 32'hFFFF0000
`define PVSC_WM_CTL 32'h00000007
`define PVSC_WM_MADR 32'hFFFFFFFC
`define PVSC_WM_ALL 32'hFFFFFFFF
`define PVSC_WM_MISC 32'hF7000000
`define PVSC_RST_VAL 32'h00000000

`define PVSC_CTL_SEL 1:0
`define PVSC_CTL_IO 2
`define PVSC_MISC_CWT 26:24

`define PVSC_SEL_OFF 2'h0
`define PVSC_SEL_RMW 2'h1
`define PVSC_SEL_ADO 2'h2

`define PVSC_CWT_16 10'h010
`define PVSC_CWT_32 10'h020
`define PVSC_CWT_64 10'h040
`define PVSC_CWT_128 10'h080
`define PVSC_CWT_246 10'h0F6
`define PVSC_CWT_512 10'h200
`define PVSC_CWT_NONE 10'h000

`define PVSC_RESP_OKAY 2'h0
`define PVSC_RESP_SLVERR 2'h2

`endif

// >>> core/pvsc_top.v
// PCI target image 3 decode, address translation and special cycle
// generator (read-modify-write and address-only) with coupled hold.
// PCI and VME request ports come from logic on mclk_i; no syncing.
`timescale 1ns/1ps
`include "pvsc_map.vh"
module pvsc_top (
  // Clock, reset, enable
  input wire mclk_i,
  input wire reset_n_i,
  input wire ce_i,
  // AXI4-Lite write
  input wire [11:0] s_axi_awaddr_i,
  input wire s_axi_awvalid_i,
  output wire s_axi_awready_o,
  input wire [31:0] s_axi_wdata_i,
  input wire [3:0] s_axi_wstrb_i,
  input wire s_axi_wvalid_i,
  output wire s_axi_wready_o,
  output wire [1:0] s_axi_bresp_o,
  output wire s_axi_bvalid_o,
  input wire s_axi_bready_i,
  // AXI4-Lite read
  input wire [11:0] s_axi_araddr_i,
  input wire s_axi_arvalid_i,
  output wire s_axi_arready_o,
  output wire [31:0] s_axi_rdata_o,
  output wire [1:0] s_axi_rresp_o,
  output wire s_axi_rvalid_o,
  input wire s_axi_rready_i,
  // PCI side request
  input wire pci_req_i,
  input wire [31:0] pci_addr_i,
  input wire pci_io_i,
  input wire pci_wr_i,
  input wire [31:0] pci_wdata_i,
  output wire pci_busy_o,
  output wire pci_done_o,
  output wire pci_claim_o,
  output wire pci_ack64_o,
  output wire [31:0] pci_rdata_o,
  // VME side request
  output wire vme_req_o,
  output wire [31:0] vme_addr_o,
  output wire vme_wr_o,
  output wire vme_adonly_o,
  output wire vme_lock_o,
  output wire [31:0] vme_wdata_o,
  output wire [31:0] vme_wmask_o,
  output wire vme_own_o,
  input wire vme_ack_i,
  input wire [31:0] vme_rdata_i
);

  localparam S_IDLE = 2'h0;
  localparam S_XFER = 2'h1;
  localparam S_RMWR = 2'h2;
  localparam S_RMWW = 2'h3;

  reg rst_s1_q;
  reg rst_s2_q;

  always @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rst_s1_q <= 1'b0;
      rst_s2_q <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_s2_q <= rst_s1_q;
    end
  end
  wire rst_n = rst_s2_q;

  function [3:0] idx_of;
    input [11:0] a;
    begin
      case (a)
        `PVSC_OFS_FLOOR: idx_of = `PVSC_IDX_FLOOR;
        `PVSC_OFS_LIMIT: idx_of = `PVSC_IDX_LIMIT;
        `PVSC_OFS_TOFF: idx_of = `PVSC_IDX_TOFF;
        `PVSC_OFS_CTL: idx_of = `PVSC_IDX_CTL;
        `PVSC_OFS_MADR: idx_of = `PVSC_IDX_MADR;
        `PVSC_OFS_MASK: idx_of = `PVSC_IDX_MASK;
        `PVSC_OFS_CMP: idx_of = `PVSC_IDX_CMP;
        `PVSC_OFS_SWP: idx_of = `PVSC_IDX_SWP;
        `PVSC_OFS_MISC: idx_of = `PVSC_IDX_MISC;
        `PVSC_OFS_STAT: idx_of = `PVSC_IDX_STAT;
        default: idx_of = `PVSC_IDX_NONE;
      endcase
    end
  endfunction

  // Writable bits per register; reserved bits stay zero
  function [31:0] wmask_of;
    input [3:0] i;
    begin
      case (i)
        `PVSC_IDX_FLOOR: wmask_of = `PVSC_WM_IMG;
        `PVSC_IDX_LIMIT: wmask_of = `PVSC_WM_IMG;
        `PVSC_IDX_TOFF: wmask_of = `PVSC_WM_IMG;
        `PVSC_IDX_CTL: wmask_of = `PVSC_WM_CTL;
        `PVSC_IDX_MADR: wmask_of = `PVSC_WM_MADR;
        `PVSC_IDX_MASK: wmask_of = `PVSC_WM_ALL;
        `PVSC_IDX_CMP: wmask_of = `PVSC_WM_ALL;
        `PVSC_IDX_SWP: wmask_of = `PVSC_WM_ALL;
        `PVSC_IDX_MISC: wmask_of = `PVSC_WM_MISC;
        default: wmask_of = `PVSC_RST_VAL;
      endcase
    end
  endfunction

  // AXI write channel state
  reg awready_q, wready_q, aw_got_q, w_got_q, bvalid_q;
  reg [11:0] awaddr_q;
  reg [31:0] wdata_q;
  reg [3:0] wstrb_q;
  reg [1:0] bresp_q;
  // AXI read channel state
  reg arready_q, rvalid_q;
  reg [31:0] rdata_q;
  reg [1:0] rresp_q;

  reg [31:0] rf_q [0:`PVSC_NREG-1];
  wire [3:0] widx = idx_of(awaddr_q);
  wire [3:0] ridx = idx_of(s_axi_araddr_i);
  wire wr_go = ce_i && aw_got_q && w_got_q && !bvalid_q;
  wire [31:0] wbits = {{8{wstrb_q[3]}}, {8{wstrb_q[2]}},
                       {8{wstrb_q[1]}}, {8{wstrb_q[0]}}};

  genvar gi;
  generate
    for (gi = 0; gi < `PVSC_NREG; gi = gi + 1) begin : g_reg
      wire [31:0] m;
      assign m = wbits & wmask_of(gi[3:0]);
      always @(posedge mclk_i or negedge rst_n) begin
        if (!rst_n) begin
          rf_q[gi] <= `PVSC_RST_VAL;
        end else if (wr_go && widx == gi[3:0]) begin
          rf_q[gi] <= (rf_q[gi] & ~m) | (wdata_q & m);
        end
      end
    end
  endgenerate

  always @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      awready_q <= 1'b1;
      wready_q <= 1'b1;
      aw_got_q <= 1'b0;
      w_got_q <= 1'b0;
      awaddr_q <= 12'h000;
      wdata_q <= `PVSC_RST_VAL;
      wstrb_q <= 4'h0;
      bvalid_q <= 1'b0;
      bresp_q <= `PVSC_RESP_OKAY;
    end else if (ce_i) begin
      if (s_axi_awvalid_i && awready_q) begin
        awready_q <= 1'b0;
        aw_got_q <= 1'b1;
        awaddr_q <= s_axi_awaddr_i;
      end
      if (s_axi_wvalid_i && wready_q) begin
        wready_q <= 1'b0;
        w_got_q <= 1'b1;
        wdata_q <= s_axi_wdata_i;
        wstrb_q <= s_axi_wstrb_i;
      end
      if (wr_go) begin
        aw_got_q <= 1'b0;
        w_got_q <= 1'b0;
        bvalid_q <= 1'b1;
        // Status is read-only, so writes to it are refused too
        if (widx == `PVSC_IDX_NONE || widx == `PVSC_IDX_STAT) begin
          bresp_q <= `PVSC_RESP_SLVERR;
        end else begin
          bresp_q <= `PVSC_RESP_OKAY;
        end
      end
      if (bvalid_q && s_axi_bready_i) begin
        bvalid_q <= 1'b0;
        awready_q <= 1'b1;
        wready_q <= 1'b1;
      end
    end
  end

  // Generator state
  reg [1:0] state_q;
  reg busy_q, done_q, claim_q, ack64_q, vreq_q, vwr_q, vado_q, vlock_q;
  reg own_q, cmp_ok_q, spc_seen_q;
  reg [31:0] prdata_q, vaddr_q, vwdata_q, vwmask_q;
  reg [9:0] tmr_q;
  reg [9:0] hold_cnt;
  wire [31:0] floor_w = rf_q[`PVSC_IDX_FLOOR];
  wire [31:0] limit_w = rf_q[`PVSC_IDX_LIMIT];
  wire [31:0] toff_w = rf_q[`PVSC_IDX_TOFF];
  wire [31:0] ctl_w = rf_q[`PVSC_IDX_CTL];
  wire [31:0] madr_w = rf_q[`PVSC_IDX_MADR];
  wire [31:0] mask_w = rf_q[`PVSC_IDX_MASK];
  wire [31:0] cmp_w = rf_q[`PVSC_IDX_CMP];
  wire [31:0] swp_w = rf_q[`PVSC_IDX_SWP];
  wire [31:0] misc_w = rf_q[`PVSC_IDX_MISC];
  wire [1:0] sel_w = ctl_w[`PVSC_CTL_SEL];
  // Compare on the upper half only; lower bits never bound the image
  wire img_hit = (pci_addr_i[31:16] >= floor_w[31:16]) &&
                 ((limit_w[31:16] == 16'h0000) ||
                  (pci_addr_i[31:16] < limit_w[31:16]));
  wire spc_hit = (sel_w != `PVSC_SEL_OFF) &&
                 (pci_addr_i[31:2] == madr_w[31:2]) &&
                 (pci_io_i == ctl_w[`PVSC_CTL_IO]);
  // Reserved select code starts no special cycle; a match still runs a plain transfer
  wire rmw_go = spc_hit && sel_w == `PVSC_SEL_RMW && !pci_wr_i;
  wire ado_go = spc_hit && sel_w == `PVSC_SEL_ADO;
  wire [15:0] vhi = pci_addr_i[31:16] + toff_w[31:16];
  wire rd_match = ((vme_rdata_i ^ cmp_w) & mask_w) == `PVSC_RST_VAL;

  always @* begin
    case (misc_w[`PVSC_MISC_CWT])
      3'h1: hold_cnt = `PVSC_CWT_16;
      3'h2: hold_cnt = `PVSC_CWT_32;
      3'h3: hold_cnt = `PVSC_CWT_64;
      3'h4: hold_cnt = `PVSC_CWT_128;
      3'h5: hold_cnt = `PVSC_CWT_246;
      3'h6: hold_cnt = `PVSC_CWT_512;
      default: hold_cnt = `PVSC_CWT_NONE;
    endcase
  end

  always @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= S_IDLE;
      busy_q <= 1'b0;
      done_q <= 1'b0;
      claim_q <= 1'b0;
      ack64_q <= 1'b0;
      prdata_q <= `PVSC_RST_VAL;
      vreq_q <= 1'b0;
      vaddr_q <= `PVSC_RST_VAL;
      vwr_q <= 1'b0;
      vado_q <= 1'b0;
      vlock_q <= 1'b0;
      vwdata_q <= `PVSC_RST_VAL;
      vwmask_q <= `PVSC_RST_VAL;
      own_q <= 1'b0;
      tmr_q <= `PVSC_CWT_NONE;
      cmp_ok_q <= 1'b0;
      spc_seen_q <= 1'b0;
    end else if (ce_i) begin
      done_q <= 1'b0;
      case (state_q)
        S_IDLE: begin
          if (tmr_q != `PVSC_CWT_NONE) begin
            tmr_q <= tmr_q - 10'h001;
            if (tmr_q == 10'h001) begin
              own_q <= 1'b0;
            end
          end
          if (pci_req_i) begin
            claim_q <= img_hit || spc_hit;
            ack64_q <= img_hit && !spc_hit;
            vaddr_q <= {vhi, pci_addr_i[15:0]};
            vwdata_q <= pci_wdata_i;
            vwmask_q <= `PVSC_WM_ALL;
            vlock_q <= 1'b0;
            vado_q <= 1'b0;
            if (rmw_go) begin
              state_q <= S_RMWR;
              busy_q <= 1'b1;
              vreq_q <= 1'b1;
              vwr_q <= 1'b0;
              vlock_q <= 1'b1;
              own_q <= 1'b1;
              spc_seen_q <= 1'b1;
            end else if (ado_go) begin
              state_q <= S_XFER;
              busy_q <= 1'b1;
              vreq_q <= 1'b1;
              // No data phase, so never flagged as a write
              vwr_q <= 1'b0;
              vado_q <= 1'b1;
              own_q <= 1'b1;
              spc_seen_q <= 1'b1;
            end else if (img_hit || spc_hit) begin
              state_q <= S_XFER;
              busy_q <= 1'b1;
              vreq_q <= 1'b1;
              vwr_q <= pci_wr_i;
              own_q <= 1'b1;
            end else begin
              done_q <= 1'b1;
              prdata_q <= `PVSC_RST_VAL;
            end
          end
        end
        S_XFER: begin
          if (vme_ack_i) begin
            vreq_q <= 1'b0;
            vado_q <= 1'b0;
            state_q <= S_IDLE;
            busy_q <= 1'b0;
            done_q <= 1'b1;
            prdata_q <= (vwr_q || vado_q) ? `PVSC_RST_VAL : vme_rdata_i;
            tmr_q <= hold_cnt;
            own_q <= hold_cnt != `PVSC_CWT_NONE;
          end
        end
        S_RMWR: begin
          if (vme_ack_i) begin
            prdata_q <= vme_rdata_i;
            cmp_ok_q <= rd_match;
            if (rd_match) begin
              state_q <= S_RMWW;
              vwr_q <= 1'b1;
              vwmask_q <= mask_w;
              // Unmasked lanes carry the old data as a second guard
              vwdata_q <= (swp_w & mask_w) |
                          (vme_rdata_i & ~mask_w);
            end else begin
              vreq_q <= 1'b0;
              vlock_q <= 1'b0;
              state_q <= S_IDLE;
              busy_q <= 1'b0;
              done_q <= 1'b1;
              tmr_q <= hold_cnt;
              own_q <= hold_cnt != `PVSC_CWT_NONE;
            end
          end
        end
        S_RMWW: begin
          if (vme_ack_i) begin
            vreq_q <= 1'b0;
            vwr_q <= 1'b0;
            vlock_q <= 1'b0;
            state_q <= S_IDLE;
            busy_q <= 1'b0;
            done_q <= 1'b1;
            tmr_q <= hold_cnt;
            own_q <= hold_cnt != `PVSC_CWT_NONE;
          end
        end
        default: begin
          state_q <= S_IDLE;
          busy_q <= 1'b0;
          vreq_q <= 1'b0;
        end
      endcase
    end
  end

  // Status word: busy, ownership, last compare, special seen
  wire [31:0] stat_w = {28'h0000000, spc_seen_q, cmp_ok_q, own_q, busy_q};

  always @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      arready_q <= 1'b1;
      rvalid_q <= 1'b0;
      rdata_q <= `PVSC_RST_VAL;
      rresp_q <= `PVSC_RESP_OKAY;
    end else if (ce_i) begin
      if (s_axi_arvalid_i && arready_q) begin
        arready_q <= 1'b0;
        rvalid_q <= 1'b1;
        rresp_q <= `PVSC_RESP_OKAY;
        if (ridx == `PVSC_IDX_STAT) begin
          rdata_q <= stat_w;
        end else if (ridx == `PVSC_IDX_NONE) begin
          rdata_q <= `PVSC_RST_VAL;
          rresp_q <= `PVSC_RESP_SLVERR;
        end else begin
          rdata_q <= rf_q[ridx];
        end
      end
      if (rvalid_q && s_axi_rready_i) begin
        rvalid_q <= 1'b0;
        arready_q <= 1'b1;
      end
    end
  end

  assign s_axi_awready_o = awready_q;
  assign s_axi_wready_o = wready_q;
  assign s_axi_bresp_o = bresp_q;
  assign s_axi_bvalid_o = bvalid_q;
  assign s_axi_arready_o = arready_q;
  assign s_axi_rdata_o = rdata_q;
  assign s_axi_rresp_o = rresp_q;
  assign s_axi_rvalid_o = rvalid_q;
  assign pci_busy_o = busy_q;
  assign pci_done_o = done_q;
  assign pci_claim_o = claim_q;
  assign pci_ack64_o = ack64_q;
  assign pci_rdata_o = prdata_q;
  assign vme_req_o = vreq_q;
  assign vme_addr_o = vaddr_q;
  assign vme_wr_o = vwr_q;
  assign vme_adonly_o = vado_q;
  assign vme_lock_o = vlock_q;
  assign vme_wdata_o = vwdata_q;
  assign vme_wmask_o = vwmask_q;
  assign vme_own_o = own_q;

endmodule

// >>> tb/pvsc_sva.sv
// Checker for pvsc_top: PCI answer kinds and VME special cycles.
// Assumes a single mclk_i domain; bound into every pvsc_top.
`timescale 1ns/1ps
module pvsc_chk (
  // Clock, reset, enable
  input wire mclk_i,
  input wire reset_n_i,
  input wire ce_i,
  // PCI side
  input wire pci_req_i,
  input wire [31:0] pci_addr_i,
  input wire pci_busy_o,
  input wire pci_done_o,
  input wire pci_claim_o,
  input wire pci_ack64_o,
  input wire [31:0] pci_rdata_o,
  // VME side
  input wire vme_req_o,
  input wire [31:0] vme_addr_o,
  input wire vme_wr_o,
  input wire vme_adonly_o,
  input wire vme_lock_o,
  input wire [31:0] vme_wdata_o,
  input wire [31:0] vme_wmask_o,
  input wire vme_ack_i,
  input wire [31:0] vme_rdata_i
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!reset_n_i);
  sequence s_rd_ack;
    vme_req_o && vme_lock_o && !vme_wr_o && vme_ack_i;
  endsequence
  sequence s_take;
    pci_req_i && !pci_busy_o && ce_i;
  endsequence
  a_no_ack64: assert property (
    (vme_lock_o || vme_adonly_o) |-> !pci_ack64_o)
    else $error("ack64 offered on special cycle");
  a_rmw_read_first: assert property (
    $rose(vme_lock_o) |-> vme_req_o && !vme_wr_o)
    else $error("locked sequence did not open with a read");
  a_rmw_next_step: assert property (
    s_rd_ack |=> (vme_lock_o && vme_wr_o && vme_req_o)
    || (!vme_lock_o && pci_done_o))
    else $error("wrong step after locked read");
  a_rdata_return: assert property (
    s_rd_ack |=> pci_rdata_o == $past(vme_rdata_i))
    else $error("locked read data not returned");
  a_unmasked_kept: assert property (
    vme_lock_o && vme_wr_o
    |-> ((vme_wdata_o ^ pci_rdata_o) & ~vme_wmask_o) == 32'h0)
    else $error("unmasked bits altered in write back");
  a_low_addr: assert property (
    s_take |=> !vme_req_o || vme_addr_o[15:0] == $past(pci_addr_i[15:0]))
    else $error("low address bits not passed through");
  a_answer_kind: assert property (
    s_take |=> pci_claim_o ? pci_busy_o && !pci_done_o
    : pci_done_o && !pci_busy_o)
    else $error("wrong answer to taken request");
  a_adonly_plain: assert property (
    vme_adonly_o |-> !vme_wr_o && !vme_lock_o)
    else $error("address-only cycle carries data phase");
endmodule
bind pvsc_top pvsc_chk i_pvsc_chk (.*);

// >>> tb/pvsc_vme_model.sv
// VME slave model: 16-word memory, random wait before each ack.
// Assumes the core holds a request until a one-cycle ack.
`timescale 1ns/1ps
module pvsc_vme_model (
  // Clock
  input wire mclk_i,
  // Request from the core
  input wire req_i,
  input wire [31:0] addr_i,
  input wire wr_i,
  input wire adonly_i,
  input wire [31:0] wdata_i,
  input wire [31:0] wmask_i,
  // Answer to the core
  output reg ack_o,
  output reg [31:0] rdata_o
);
  reg [31:0] mem [0:15];
  integer wait_n = 0;
  initial begin
    ack_o = 1'h0;
    rdata_o = 32'h0;
  end
  always @(posedge mclk_i) begin
    ack_o <= 1'h0;
    // Released data lines toggle so a stale value never passes
    rdata_o <= ~rdata_o;
    if (req_i && !ack_o && wait_n > 0)
      wait_n <= wait_n - 1;
    else if (req_i && !ack_o) begin
      ack_o <= 1'h1;
      wait_n <= $urandom % 4;
      if (!wr_i && !adonly_i)
        rdata_o <= mem[addr_i[5:2]];
      if (wr_i)
        mem[addr_i[5:2]] <= mem[addr_i[5:2]] & ~wmask_i | wdata_i & wmask_i;
    end
  end
endmodule

// >>> tb/pvsc_top_tb.sv
// Bench for pvsc_top: registers, image decode, special cycles, timer.
// Assumes the VME model answers every request within a few cycles.
`timescale 1ns/1ps
`include "pvsc_map.vh"
module pvsc_top_tb;
  reg mclk_i = 1'h0;
  reg reset_n_i = 1'h0;
  reg ce_i = 1'h1;
  reg [11:0] s_axi_awaddr_i = 12'h0;
  reg [11:0] s_axi_araddr_i = 12'h0;
  reg [31:0] s_axi_wdata_i = 32'h0;
  reg [3:0] s_axi_wstrb_i = 4'hF;
  reg s_axi_awvalid_i = 1'h0;
  reg s_axi_wvalid_i = 1'h0;
  reg s_axi_bready_i = 1'h0;
  reg s_axi_arvalid_i = 1'h0;
  reg s_axi_rready_i = 1'h0;
  reg pci_req_i = 1'h0;
  reg pci_io_i = 1'h0;
  reg pci_wr_i = 1'h0;
  reg [31:0] pci_addr_i = 32'h0;
  reg [31:0] pci_wdata_i = 32'h0;
  wire s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o, s_axi_arready_o;
  wire s_axi_rvalid_o, pci_busy_o, pci_done_o, pci_claim_o, pci_ack64_o;
  wire vme_req_o, vme_wr_o, vme_adonly_o, vme_lock_o, vme_own_o, vme_ack_i;
  wire [1:0] s_axi_bresp_o, s_axi_rresp_o;
  wire [31:0] s_axi_rdata_o, pci_rdata_o, vme_addr_o, vme_wdata_o;
  wire [31:0] vme_wmask_o, vme_rdata_i;
  reg [33:0] q_rd [$];
  reg [1:0] q_b [$];
  reg [34:0] q_pci [$];
  reg [34:0] q_vme [$];
  reg [31:0] vm [0:15];
  reg [34:0] pe;
  reg [31:0] a, d, m;
  reg [3:0] stb = 4'hF;
  integer i, k;
  integer err_count = 0;
  integer n_compared = 0;
  pvsc_top i_pvsc_top (.*);
  pvsc_vme_model i_pvsc_vme_model (.mclk_i(mclk_i), .req_i(vme_req_o),
    .addr_i(vme_addr_o), .wr_i(vme_wr_o), .adonly_i(vme_adonly_o),
    .wdata_i(vme_wdata_o), .wmask_i(vme_wmask_o), .ack_o(vme_ack_i),
    .rdata_o(vme_rdata_i));
  always #2 mclk_i = ~mclk_i;
  task test_done;
    $display("compared %0d, mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task tally(input ok, input [95:0] s);
    n_compared++;
    if (!ok) begin
      err_count++;
      $display("mismatch at %0t: %0s", $time, s);
    end
  endtask
  task tmo;
    tally(1'h0, "timeout");
    test_done;
  endtask
  task chk_rd(input [33:0] g, e);
    tally(g === e, "axi read");
  endtask
  task chk_b(input [1:0] g, e);
    tally(g === e, "axi write");
  endtask
  task chk_pci(input [33:0] g, e);
    tally(g === e, "pci result");
  endtask
  task chk_vme(input [34:0] g, e);
    tally(g === e, "vme phase");
  endtask
  task chk_val(input [31:0] g, e);
    tally(g === e, "value");
  endtask
  function [11:0] ra(input integer n);
    ra = 12'((n < 3 ? 32'h140 : 32'h164) + 4 * n);
  endfunction
  function [31:0] wm(input integer n);
    wm = n < 3 ? `PVSC_WM_IMG : n == 3 ? `PVSC_WM_CTL : n == 4 ?
      `PVSC_WM_MADR : n == 8 ? `PVSC_WM_MISC : `PVSC_WM_ALL;
  endfunction
  function [31:0] va(input [31:0] x);
    va = {x[31:16] + 16'hF300, x[15:0]};
  endfunction
  always @(posedge mclk_i) begin
    if (s_axi_rvalid_o && s_axi_rready_i)
      chk_rd({s_axi_rresp_o, s_axi_rdata_o}, q_rd.pop_front());
    if (s_axi_bvalid_o && s_axi_bready_i)
      chk_b(s_axi_bresp_o, q_b.pop_front());
    if (vme_req_o && vme_ack_i)
      chk_vme({vme_wr_o, vme_adonly_o, vme_lock_o, vme_addr_o},
        q_vme.pop_front());
    if (pci_done_o) begin
      pe = q_pci.pop_front();
      chk_pci({pci_claim_o, pci_ack64_o & pe[34], pci_rdata_o}, pe[33:0]);
    end
  end
  task wr(input [11:0] ad, input [31:0] dt, input [1:0] r);
    integer j;
    q_b.push_back(r);
    s_axi_awaddr_i <= ad;
    s_axi_wdata_i <= dt;
    s_axi_wstrb_i <= stb;
    s_axi_awvalid_i <= 1'h1;
    s_axi_wvalid_i <= 1'h1;
    s_axi_bready_i <= 1'h1;
    for (j = 0; j < 99; j++) begin
      @(posedge mclk_i);
      if (s_axi_awready_o) s_axi_awvalid_i <= 1'h0;
      if (s_axi_wready_o) s_axi_wvalid_i <= 1'h0;
      if (s_axi_bvalid_o) break;
    end
    s_axi_bready_i <= 1'h0;
    if (j == 99) tmo;
    @(posedge mclk_i);
  endtask
  task rd(input [11:0] ad, input [33:0] e);
    integer j;
    q_rd.push_back(e);
    s_axi_araddr_i <= ad;
    s_axi_arvalid_i <= 1'h1;
    s_axi_rready_i <= 1'h1;
    for (j = 0; j < 99; j++) begin
      @(posedge mclk_i);
      if (s_axi_arready_o) s_axi_arvalid_i <= 1'h0;
      if (s_axi_rvalid_o) break;
    end
    s_axi_rready_i <= 1'h0;
    if (j == 99) tmo;
    @(posedge mclk_i);
  endtask
  task pci(input [31:0] ad, input io, input w, input [34:0] e);
    integer j;
    q_pci.push_back(e);
    pci_addr_i <= ad;
    pci_io_i <= io;
    pci_wr_i <= w;
    pci_wdata_i <= $urandom;
    pci_req_i <= 1'h1;
    @(posedge mclk_i);
    pci_req_i <= 1'h0;
    for (j = 0; j < 99; j++) begin
      @(posedge mclk_i);
      if (pci_done_o) break;
    end
    if (j == 99) tmo;
  endtask
  task ex(input [31:0] ad, input io, input hit);
    if (hit) q_vme.push_back({3'h0, va(ad)});
    pci(ad, io, 1'h0, {1'h1, hit, hit, hit ? vm[ad[5:2]] : 32'h0});
  endtask
  initial begin
    i = $urandom(24);
    for (i = 0; i < 16; i++) begin
      vm[i] = $urandom;
      i_pvsc_vme_model.mem[i] = vm[i];
    end
    repeat (16) @(posedge mclk_i);
    reset_n_i <= 1'h1;
    repeat (5) @(posedge mclk_i);
    for (i = 0; i < 9; i++) rd(ra(i), 34'h0);
    rd(12'h14C, {2'h2, 32'h0});
    wr(12'h14C, 32'h1, 2'h2);
    stb = 4'h3;
    wr(12'h180, 32'hFFFFFFFF, 2'h0);
    stb = 4'hF;
    rd(12'h180, {2'h0, 32'h0000FFFF});
    for (i = 0; i < 9; i++) wr(ra(i), 32'hFFFFFFFF, 2'h0);
    for (i = 0; i < 9; i++) rd(ra(i), {2'h0, wm(i)});
    wr(12'h140, 32'h10000000, 2'h0);
    wr(12'h144, 32'h20000000, 2'h0);
    wr(12'h148, 32'hF3000000, 2'h0);
    wr(12'h170, 32'h0, 2'h0);
    wr(12'h184, 32'h0, 2'h0);
    ex(32'h0FFFFFFC, 1'h0, 1'h0);
    ex(32'h20000000, 1'h0, 1'h0);
    for (i = 0; i < 4; i++) begin
      a = 32'h10000000 | $urandom & 32'h0FFFFFFC;
      ex(a, 1'h0, 1'h1);
    end
    wr(12'h144, 32'h0, 2'h0);
    ex(32'hFFFF0008, 1'h0, 1'h1);
    a = 32'h10000044;
    m = 32'h0000FFFF;
    d = vm[1];
    wr(12'h174, a, 2'h0);
    wr(12'h178, m, 2'h0);
    wr(12'h17C, d ^ ~m, 2'h0);
    // Inverse swap makes the repeated compare miss for any old data
    wr(12'h180, ~d, 2'h0);
    wr(12'h170, 32'h1, 2'h0);
    q_vme.push_back({3'h1, va(a)});
    q_vme.push_back({3'h5, va(a)});
    pci(a, 1'h0, 1'h0, {3'h6, d});
    vm[1] = ~d & m | d & ~m;
    chk_val(i_pvsc_vme_model.mem[1], vm[1]);
    q_vme.push_back({3'h1, va(a)});
    pci(a, 1'h0, 1'h0, {3'h6, vm[1]});
    chk_val(i_pvsc_vme_model.mem[1], vm[1]);
    ex(a, 1'h1, 1'h1);
    ex(a + 4, 1'h0, 1'h1);
    for (i = 0; i < 3; i++) begin
      k = i * 2 + i / 2 * 2;
      wr(12'h170, k, 2'h0);
      q_vme.push_back({k ? 3'h2 : 3'h4, va(a)});
      pci(a, k[2], 1'h1, {k ? 3'h6 : 3'h2, 32'h0});
    end
    for (i = 0; i < 7; i++) begin
      wr(12'h184, i << 24, 2'h0);
      ex(32'h10000100, 1'h0, 1'h1);
      @(negedge mclk_i);
      // First look is one cycle after done; count that cycle too
      for (k = vme_own_o; k < 600 && vme_own_o; k++) @(negedge mclk_i);
      chk_val(k, i == 0 ? 0 : i == 5 ? 246 : 8 << i);
      @(posedge mclk_i);
    end
    test_done;
  end
endmodule
